//--- design/supervisor_defs.svh
// timing constants for the supply supervisor
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH
`define CLK_PERIOD_NS 8
`define RESET_HOLD_MS 200
`define RESET_HOLD_CYC ((`RESET_HOLD_MS * 1000000) / `CLK_PERIOD_NS)
`define WDOG_PERIOD_MS 1600
`define WDOG_PERIOD_CYC ((`WDOG_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)
`define CE_HOLD_US 10
`define CE_HOLD_CYC ((`CE_HOLD_US * 1000) / `CLK_PERIOD_NS)
`endif

//--- design/supervisor_pkg.sv
// types for the supply supervisor
package supervisor_pkg;
  typedef enum logic [1:0] {
    RST_ACTIVE = 2'b00,
    RST_HOLD = 2'b01,
    RST_RUN = 2'b11
  } rst_state_t;
  typedef enum logic [1:0] {
    SRC_MAIN = 2'b00,
    SRC_BACKUP_CELL_IN = 2'b01,
    SRC_SEALED = 2'b11
  } src_state_t;
endpackage

//--- design/watchdog_timer.sv
// watchdog timer with edge detect and fault flag
`include "supervisor_defs.svh"
module watchdog_timer
  import supervisor_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = `WDOG_PERIOD_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic kick_i,
  input wire logic hold_clear_i,
  output logic fault_o
);
  logic kick_d_reg;
  logic [31:0] count_reg;
  logic toggle;

  assign toggle = kick_i ^ kick_d_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      kick_d_reg <= 1'b0;
    end else begin
      kick_d_reg <= kick_i;
    end
  end

  // count cleared in reset; any edge restarts from zero
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || hold_clear_i || toggle) begin
      count_reg <= 32'h0;
    end else if (count_reg < PERIOD_CYC) begin
      count_reg <= count_reg + 32'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || hold_clear_i) begin
      fault_o <= 1'b0;
    end else if (toggle) begin
      fault_o <= 1'b0;
    end else if (count_reg == PERIOD_CYC - 1) begin
      fault_o <= 1'b1;
    end
  end

  chk_fault_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    fault_o && toggle && !hold_clear_i |=> !fault_o)
    else $error("fault not cleared by kick edge");
  chk_hold_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    hold_clear_i |=> count_reg == 32'h0)
    else $error("watchdog counted during reset");
endmodule

//--- design/supply_supervisor_watchdog.sv
// supply supervisor: reset, watchdog, backup switchover, chip-enable gating
`include "supervisor_defs.svh"
module supply_supervisor_watchdog
  import supervisor_pkg::*;
#(
  parameter int unsigned RESET_HOLD_CYC = `RESET_HOLD_CYC,
  parameter int unsigned WDOG_PERIOD_CYC = `WDOG_PERIOD_CYC,
  parameter int unsigned CE_HOLD_CYC = `CE_HOLD_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic supply_below_reset_i,
  input wire logic supply_below_switch_i,
  input wire logic supply_below_early_supply_warning_n_i,
  input wire logic supply_below_cell_i,
  input wire logic supply_below_min_i,
  input wire logic cell_above_reset_i,
  input wire logic cell_above_good_i,
  input wire logic powerfail_sense_in_i,
  input wire logic manual_reset_n_i,
  input wire logic watchdog_kick_in_i,
  input wire logic chip_select_n_i,
  input wire logic powerfail_flag_n_i,
  output logic reset_n_o,
  output logic reset_o,
  output logic watchdog_fault_n_o,
  output logic chip_select_n_o,
  output logic backup_active_o,
  output logic backup_healthy_o,
  output logic powerfail_flag_n_o,
  output logic powerfail_flag_n_oe_o,
  output logic early_supply_warning_n_o,
  output logic seal_armed_o
);
  // ==========================================
  // input registers
  logic below_rst_reg, below_sw_reg, below_ll_reg, below_cell_reg, below_min_reg;
  logic cell_rst_reg, cell_ok_reg, pf_sense_reg, mr_n_reg, kick_reg, cs_n_reg;
  logic pf_forced_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      below_rst_reg <= 1'b1;
      below_sw_reg <= 1'b1;
      below_ll_reg <= 1'b1;
      below_cell_reg <= 1'b1;
      below_min_reg <= 1'b1;
      cell_rst_reg <= 1'b0;
      cell_ok_reg <= 1'b0;
      pf_sense_reg <= 1'b0;
      mr_n_reg <= 1'b1;
      kick_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      pf_forced_reg <= 1'b0;
    end else begin
      below_rst_reg <= supply_below_reset_i;
      below_sw_reg <= supply_below_switch_i;
      below_ll_reg <= supply_below_early_supply_warning_n_i;
      below_cell_reg <= supply_below_cell_i;
      below_min_reg <= supply_below_min_i;
      cell_rst_reg <= cell_above_reset_i;
      cell_ok_reg <= cell_above_good_i;
      pf_sense_reg <= powerfail_sense_in_i;
      mr_n_reg <= manual_reset_n_i;
      kick_reg <= watchdog_kick_in_i;
      cs_n_reg <= chip_select_n_i;
      // pin read back low while we drive it high: forced externally
      // a released low flag reads low through the pull-down, so it cannot count
      pf_forced_reg <= !powerfail_flag_n_i && powerfail_flag_n_oe_o;
    end
  end

  // ==========================================
  // reset generator
  rst_state_t rst_state_reg;
  logic [31:0] hold_cnt_reg;
  logic first_half;
  logic mr_low;
  logic trigger;

  assign first_half = (rst_state_reg == RST_HOLD) && (hold_cnt_reg < RESET_HOLD_CYC / 2);
  assign mr_low = !mr_n_reg && !(first_half && pf_forced_reg);
  assign trigger = below_rst_reg || mr_low;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rst_state_reg <= RST_ACTIVE;
      hold_cnt_reg <= 32'h0;
    end else begin
      case (rst_state_reg)
        RST_ACTIVE: begin
          hold_cnt_reg <= 32'h0;
          if (!trigger) begin
            rst_state_reg <= RST_HOLD;
          end
        end
        RST_HOLD: begin
          if (trigger) begin
            rst_state_reg <= RST_ACTIVE;
            hold_cnt_reg <= 32'h0;
          end else if (hold_cnt_reg == RESET_HOLD_CYC - 1) begin
            rst_state_reg <= RST_RUN;
          end else begin
            hold_cnt_reg <= hold_cnt_reg + 32'h1;
          end
        end
        RST_RUN: begin
          if (trigger) begin
            rst_state_reg <= RST_ACTIVE;
          end
        end
        default: begin
          rst_state_reg <= RST_ACTIVE;
        end
      endcase
    end
  end

  logic in_reset;
  assign in_reset = rst_state_reg != RST_RUN;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      reset_n_o <= 1'b0;
      reset_o <= 1'b1;
    end else begin
      reset_n_o <= !in_reset;
      reset_o <= in_reset;
    end
  end

  chk_reset_inverse: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    reset_o == !reset_n_o)
    else $error("reset outputs not inverse");
  chk_reset_on_low: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    trigger |=> ##1 !reset_n_o)
    else $error("reset not asserted on trigger");
  chk_hold_count: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    reset_n_o |-> $past(hold_cnt_reg) == RESET_HOLD_CYC - 1 || $past(reset_n_o))
    else $error("reset released early");
  chk_mr_ignored: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    first_half && pf_forced_reg && !below_rst_reg |=> rst_state_reg == RST_HOLD)
    else $error("manual reset honoured in first half of hold");

  // ==========================================
  // watchdog
  logic wd_fault;

  watchdog_timer #(
    .PERIOD_CYC(WDOG_PERIOD_CYC)
  ) u_wdog (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .kick_i(kick_reg),
    .hold_clear_i(in_reset),
    .fault_o(wd_fault)
  );

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      watchdog_fault_n_o <= 1'b0;
    end else if (below_sw_reg) begin
      watchdog_fault_n_o <= 1'b0;
    end else if (below_rst_reg) begin
      watchdog_fault_n_o <= 1'b1;
    end else begin
      watchdog_fault_n_o <= !wd_fault;
    end
  end

  chk_fault_low_supply: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    below_sw_reg |=> !watchdog_fault_n_o)
    else $error("watchdog output not low below switchover");

  // ==========================================
  // chip-enable gating
  logic [15:0] ce_cnt_reg;
  logic ce_pass_reg;

  // a cycle already in flight is allowed to finish for a bounded time
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ce_pass_reg <= 1'b0;
      ce_cnt_reg <= 16'h0;
    end else if (!in_reset) begin
      ce_pass_reg <= 1'b1;
      ce_cnt_reg <= 16'h0;
    end else if (cs_n_reg || ce_cnt_reg == CE_HOLD_CYC[15:0] - 16'h1) begin
      ce_pass_reg <= 1'b0;
    end else if (ce_pass_reg) begin
      ce_cnt_reg <= ce_cnt_reg + 16'h1;
    end
  end

  assign chip_select_n_o = cs_n_reg || !ce_pass_reg;

  chk_ce_blocked: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    in_reset && cs_n_reg |=> chip_select_n_o)
    else $error("chip select passed during reset");
  chk_ce_release: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    in_reset && ce_cnt_reg == CE_HOLD_CYC[15:0] - 16'h1 |=> chip_select_n_o)
    else $error("chip select held past its window");

  // ==========================================
  // supply switchover and seal
  src_state_t src_state_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      src_state_reg <= SRC_BACKUP_CELL_IN;
    end else begin
      case (src_state_reg)
        SRC_MAIN: begin
          if (below_min_reg || (below_sw_reg && below_cell_reg)) begin
            src_state_reg <= pf_forced_reg && seal_armed_o ? SRC_SEALED : SRC_BACKUP_CELL_IN;
          end
        end
        SRC_BACKUP_CELL_IN: begin
          if (!below_min_reg && (cell_rst_reg ? !below_rst_reg : !below_cell_reg)) begin
            src_state_reg <= SRC_MAIN;
          end
        end
        SRC_SEALED: begin
          if (!below_rst_reg) begin
            src_state_reg <= SRC_MAIN;
          end
        end
        default: begin
          src_state_reg <= SRC_BACKUP_CELL_IN;
        end
      endcase
    end
  end

  // seal arms once reset releases with the flag pin grounded
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      seal_armed_o <= 1'b0;
    end else if (!in_reset && pf_forced_reg) begin
      seal_armed_o <= 1'b1;
    end else if (src_state_reg == SRC_SEALED && !below_rst_reg) begin
      seal_armed_o <= 1'b0;
    end
  end

  assign backup_active_o = src_state_reg == SRC_BACKUP_CELL_IN;

  chk_min_battery: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    below_min_reg && src_state_reg == SRC_MAIN |=> src_state_reg != SRC_MAIN)
    else $error("main supply kept below minimum");
  chk_seal_source: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    src_state_reg == SRC_MAIN && below_min_reg && seal_armed_o && pf_forced_reg
      |=> src_state_reg == SRC_SEALED)
    else $error("battery not sealed on power down");

  // ==========================================
  // status flags
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      backup_healthy_o <= 1'b0;
      powerfail_flag_n_o <= 1'b0;
      early_supply_warning_n_o <= 1'b0;
    end else begin
      if (below_sw_reg) begin
        backup_healthy_o <= 1'b0;
      end else if (!in_reset) begin
        backup_healthy_o <= cell_ok_reg;
      end
      powerfail_flag_n_o <= !(pf_sense_reg || below_sw_reg);
      early_supply_warning_n_o <= !below_ll_reg;
    end
  end

  // flag is driven only while high; a low is a released pin so a forced low reads back
  assign powerfail_flag_n_oe_o = powerfail_flag_n_o;

  chk_pf_low: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    below_sw_reg |=> !powerfail_flag_n_o)
    else $error("power fail flag high below switchover");
  chk_healthy_low: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    below_sw_reg |=> !backup_healthy_o)
    else $error("battery good flag high below switchover");
  chk_early_warn: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    below_ll_reg |=> !early_supply_warning_n_o)
    else $error("early warning high at low-line level");
endmodule

//--- testbench/host_cpu_model.sv
// far-side processor model: watchdog kicker and manual reset driver
module host_cpu_model (
  input wire logic clk_sys_i,
  input wire logic fault_n_i,
  input wire logic stall_i,
  input wire logic tie_fault_i,
  input wire logic mr_force_i,
  output logic kick_o,
  output logic manual_reset_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // kick generator
  logic [4:0] gap_reg = 5'h00;
  logic kick_reg = 1'b0;
  assign kick_o = kick_reg;
  // toggles every 20 cycles, well inside the timeout; a stall stops it dead
  always @(posedge clk_sys_i) begin
    if (!stall_i) begin
      gap_reg <= (gap_reg == 5'h13) ? 5'h00 : gap_reg + 5'h01;
      if (gap_reg == 5'h13) begin
        kick_reg <= #1 ~kick_reg;
      end
    end
  end
  // ==========================================
  // manual reset, optionally wired to the fault output
  assign manual_reset_n_o = ~mr_force_i & (tie_fault_i ? fault_n_i : 1'b1);
endmodule

//--- testbench/supply_supervisor_watchdog_tb_top.sv
// self-checking bench for the supply supervisor
module supply_supervisor_watchdog_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] sel; logic exp;} note_t;
  logic clk_sys_i, rstn_i, b_rst, b_sw, b_ll, b_cell, b_min, c_rst, c_good;
  logic sense, cs_n, stall, tie, mr_force, seal_force, kick, mr_n;
  logic rst_n, rst, fault_n, cs_o, backup_active, healthy, pf_n, pf_oe, early_n, seal;
  logic [9:0] obs;
  wire logic pf_pin;
  int num_errors = 0;
  int checked = 0;
  int seed = 32'h6fc855b1;
  note_t notes[$];
  event chk_ev;
  // pin has a pull-down, so a released pin reads low
  assign pf_pin = seal_force ? 1'b0 : (pf_oe ? pf_n : 1'b0);
  assign obs = {pf_oe, seal, early_n, pf_n, healthy, backup_active, cs_o, fault_n, rst, rst_n};
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  host_cpu_model u_cpu (.clk_sys_i(clk_sys_i), .fault_n_i(fault_n), .stall_i(stall),
    .tie_fault_i(tie), .mr_force_i(mr_force), .kick_o(kick), .manual_reset_n_o(mr_n));
  supply_supervisor_watchdog #(.RESET_HOLD_CYC(100), .WDOG_PERIOD_CYC(300),
    .CE_HOLD_CYC(10)) u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .supply_below_reset_i(b_rst), .supply_below_switch_i(b_sw),
    .supply_below_early_supply_warning_n_i(b_ll), .supply_below_cell_i(b_cell),
    .supply_below_min_i(b_min), .cell_above_reset_i(c_rst), .cell_above_good_i(c_good),
    .powerfail_sense_in_i(sense), .manual_reset_n_i(mr_n), .watchdog_kick_in_i(kick),
    .chip_select_n_i(cs_n), .powerfail_flag_n_i(pf_pin), .reset_n_o(rst_n),
    .reset_o(rst), .watchdog_fault_n_o(fault_n), .chip_select_n_o(cs_o),
    .backup_active_o(backup_active), .backup_healthy_o(healthy), .powerfail_flag_n_o(pf_n),
    .powerfail_flag_n_oe_o(pf_oe), .early_supply_warning_n_o(early_n),
    .seal_armed_o(seal));
  // ==========================================
  // shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic cmp_bit(input logic [3:0] sel, input logic exp);
    notes.push_back('{sel, exp});
    -> chk_ev;
  endtask
  task automatic finish_test();
    // let the monitor drain notes queued in this time step
    #1;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================
  // monitor: oldest note against the live outputs
  always @(chk_ev) begin
    note_t n;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      checked++;
      if (obs[n.sel] !== n.exp) begin
        num_errors++;
        $display("mismatch t=%0t bit %0d got %h exp %h", $time, n.sel, obs[n.sel], n.exp);
      end
    end
  end
  initial begin
    #40000;
    num_errors++;
    finish_test();
  end
  // ==========================================
  // scenarios
  initial begin
    {rstn_i, b_rst, b_sw, b_ll, b_cell, b_min, sense} = 7'h00;
    {c_rst, c_good, cs_n} = 3'h7;
    {stall, tie, mr_force, seal_force} = 4'h0;
    tick(5);
    rstn_i = 1'b1;
    tick(120);
    cmp_bit(0, 1'b1);
    cmp_bit(1, 1'b0);
    cmp_bit(5, 1'b1);
    cmp_bit(6, 1'b1);
    cmp_bit(4, 1'b0);
    {b_rst, b_ll} = 2'b11;
    tick(4);
    cmp_bit(0, 1'b0);
    cmp_bit(1, 1'b1);
    cmp_bit(7, 1'b0);
    {b_rst, b_ll} = 2'b00;
    tick(50);
    cmp_bit(0, 1'b0);
    tick(60);
    cmp_bit(0, 1'b1);
    cmp_bit(4, 1'b0);
    repeat (8) begin
      cs_n = 1'($random(seed));
      tick(4);
      cmp_bit(3, cs_n);
    end
    cs_n = 1'b0;
    tick(4);
    mr_force = 1'b1;
    tick(4);
    cmp_bit(3, 1'b0);
    tick(12);
    cmp_bit(3, 1'b1);
    mr_force = 1'b0;
    tick(110);
    sense = 1'b1;
    tick(4);
    cmp_bit(6, 1'b0);
    sense = 1'b0;
    c_good = 1'b0;
    tick(4);
    cmp_bit(5, 1'b0);
    c_good = 1'b1;
    stall = 1'b1;
    tick(250);
    cmp_bit(2, 1'b1);
    tick(90);
    cmp_bit(2, 1'b0);
    stall = 1'b0;
    tick(30);
    cmp_bit(2, 1'b1);
    {b_rst, b_sw, b_cell, b_min} = 4'hf;
    tick(4);
    cmp_bit(4, 1'b1);
    cmp_bit(2, 1'b0);
    cmp_bit(5, 1'b0);
    cmp_bit(6, 1'b0);
    {b_rst, b_sw, b_cell, b_min} = 4'h0;
    tick(120);
    cmp_bit(4, 1'b0);
    {tie, stall} = 2'b11;
    tick(340);
    cmp_bit(1, 1'b1);
    {tie, stall} = 2'b00;
    tick(120);
    cmp_bit(0, 1'b1);
    // freshness seal: ground the flag pin while powered down, power up, pulse manual reset
    {b_rst, b_sw, b_cell, b_min} = 4'hf;
    tick(4);
    seal_force = 1'b1;
    cmp_bit(9, 1'b0);
    {b_rst, b_sw, b_cell, b_min} = 4'h0;
    tick(20);
    mr_force = 1'b1;
    tick(4);
    mr_force = 1'b0;
    tick(86);
    cmp_bit(0, 1'b1);
    cmp_bit(8, 1'b1);
    {b_rst, b_sw, b_cell, b_min} = 4'hf;
    tick(4);
    cmp_bit(4, 1'b0);
    cmp_bit(8, 1'b1);
    seal_force = 1'b0;
    {b_rst, b_sw, b_cell, b_min} = 4'h0;
    tick(4);
    cmp_bit(8, 1'b0);
    cmp_bit(4, 1'b0);
    finish_test();
  end
endmodule
